// [rtl/psd_divider.sv]
// loadable down-counting divider with terminal pulse
`timescale 1ns/10ps
module psd_divider #(
  parameter int W = 14
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // ratio and output pulse
  input wire logic [W-1:0] i_ratio,
  output logic o_tick
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  // reload at one so the period equals the ratio
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r - W'(1);
    if (cnt_r <= W'(1)) begin
      cnt_nxt = i_ratio;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign o_tick = tick_r;
endmodule // psd_divider

// [rtl/psd_loader.sv]
// serial programming, latches, dividers, phase and lock logic
`timescale 1ns/10ps
// Function
// - shift one data bit per link clock rise
// - last bit chooses the destination latch
// - control high plus strobe loads reference latch
// - control low plus strobe loads divider latch
// - floating strobe reads high via pull-up
// - strobe high routes pump to fast-lock pin
// - polarity low inverts pump, up and down-enable outputs; pump enable unchanged
// - monitor shows reference or feedback by polarity
// - lock output low while phase differs
// - modulus bit picks 32/33 or 64/65
// - swallow count seven bits, 0 to 63
// - main count eleven bits, 16 to 2047
// - reference count fourteen bits, 8 to 16383
// - 16/19-bit shift feeding 15/18-bit latches
// - pump-down pin only pulls low
// - reference word: ratio, modulus, control high
// - divider word: swallow low, main, control low
module psd_loader #(
  parameter int SHIFT_W = psd_pkg::DIV_SHIFT_W
) (
  // system clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // serial link, on its own clock
  input wire logic I_LINK_CLK,
  input wire logic I_DATA,
  input wire logic I_LATCH_STROBE,
  input wire logic I_LATCH_STROBE_OE,
  // polarity select with pull-up
  input wire logic I_PHASE_POLARITY_SELECT,
  input wire logic I_PHASE_POLARITY_SELECT_OE,
  // prescaler pulses from the rf front end
  input wire logic I_FEEDBACK_IN,
  // charge pump pins
  output logic O_PUMP,
  output logic O_PUMP_OE,
  output logic O_PUMP_UP,
  output logic O_PUMP_DN,
  output logic O_PUMP_DN_OE,
  // fast-lock switch pin
  output logic O_FAST_LOCK_SWITCH_OUT,
  output logic O_FAST_LOCK_SWITCH_OUT_OE,
  // lock and monitor
  output logic O_LOCK_DETECT_OUT,
  output logic O_MONITOR,
  // latched settings for the prescaler and dividers
  output logic O_PRESCALER_MODULUS_BIT,
  output logic [6:0] O_PRESCALER_LOW_RATIO,
  output logic [13:0] O_REF_RATIO_BITS,
  output logic [6:0] O_SWALLOW_RATIO_BITS,
  output logic [10:0] O_MAIN_RATIO_BITS
);
  // pull-ups: an undriven pin reads high
  logic strobe_pin;
  logic pol_pin;
  assign strobe_pin = I_LATCH_STROBE_OE ? I_LATCH_STROBE : 1'b1;
  assign pol_pin = I_PHASE_POLARITY_SELECT_OE ? I_PHASE_POLARITY_SELECT : 1'b1;

  // link domain: shift register, one bit per rising edge, msb first
  logic [SHIFT_W-1:0] shift_r;
  logic [SHIFT_W-1:0] shift_nxt;
  always_comb begin
    shift_nxt = {shift_r[SHIFT_W-2:0], I_DATA};
  end
  always_ff @(posedge I_LINK_CLK) begin
    shift_r <= shift_nxt;
  end

  // strobe is asynchronous to both clocks; bring it in first
  logic strobe_s;
  psd_sync #(.W(1)) u_sync_strobe (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_d(strobe_pin),
    .o_q(strobe_s)
  );
  logic pol_s;
  psd_sync #(.W(1)) u_sync_pol (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_d(pol_pin),
    .o_q(pol_s)
  );
  // the shift register is static while the strobe is high (link idle),
  // so its bits are caught through a two-stage word sync and used once stable
  logic [SHIFT_W-1:0] word_s;
  psd_sync #(.W(SHIFT_W)) u_sync_word (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_d(shift_r),
    .o_q(word_s)
  );

  // latches, loaded while the strobe stays high
  logic [psd_pkg::REF_LATCH_W-1:0] ref_latch_r;
  logic [psd_pkg::REF_LATCH_W-1:0] ref_latch_nxt;
  logic [psd_pkg::DIV_LATCH_W-1:0] div_latch_r;
  logic [psd_pkg::DIV_LATCH_W-1:0] div_latch_nxt;
  logic ctrl_bit;
  assign ctrl_bit = word_s[0];
  always_comb begin
    ref_latch_nxt = ref_latch_r;
    div_latch_nxt = div_latch_r;
    if (strobe_s && ctrl_bit) begin
      ref_latch_nxt = word_s[psd_pkg::REF_LATCH_W:1];
    end else if (strobe_s) begin
      div_latch_nxt = word_s[psd_pkg::DIV_LATCH_W:1];
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ref_latch_r <= psd_pkg::REF_LATCH_RST;
      div_latch_r <= psd_pkg::DIV_LATCH_RST;
    end else begin
      ref_latch_r <= ref_latch_nxt;
      div_latch_r <= div_latch_nxt;
    end
  end

  // field decode
  logic [13:0] ref_ratio;
  logic [6:0] swal_ratio;
  logic [10:0] main_ratio;
  logic mod_bit;
  assign ref_ratio = ref_latch_r[psd_pkg::REF_RATIO_W-1:0];
  assign mod_bit = ref_latch_r[psd_pkg::MOD_BIT_POS];
  assign swal_ratio = div_latch_r[psd_pkg::SWAL_W-1:0];
  assign main_ratio = div_latch_r[psd_pkg::MAIN_LSB_POS +: psd_pkg::MAIN_W];

  // counters read only the latches, so old ratios hold until a transfer
  logic ref_tick;
  logic fb_tick;
  psd_divider #(.W(14)) u_ref_div (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_ratio(ref_ratio),
    .o_tick(ref_tick)
  );
  // feedback pulses come from the front end; synchronise and edge-detect
  logic fb_s;
  logic fb_d_r;
  psd_sync #(.W(1)) u_sync_fb (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_d(I_FEEDBACK_IN),
    .o_q(fb_s)
  );
  logic [10:0] main_cnt_r;
  logic [10:0] main_cnt_nxt;
  logic fb_tick_r;
  logic fb_tick_nxt;
  // main divide: one period per main_ratio prescaler pulses
  always_comb begin
    main_cnt_nxt = main_cnt_r;
    fb_tick_nxt = 1'b0;
    if (fb_s && !fb_d_r) begin
      if (main_cnt_r <= 11'h001) begin
        main_cnt_nxt = main_ratio;
        fb_tick_nxt = 1'b1;
      end else begin
        main_cnt_nxt = main_cnt_r - 11'h001;
      end
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      main_cnt_r <= 11'h000;
      fb_tick_r <= 1'b0;
      fb_d_r <= 1'b0;
    end else begin
      main_cnt_r <= main_cnt_nxt;
      fb_tick_r <= fb_tick_nxt;
      fb_d_r <= fb_s;
    end
  end
  assign fb_tick = fb_tick_r;

  // phase detector: up/down flags cleared when both have arrived
  logic up_r;
  logic up_nxt;
  logic dn_r;
  logic dn_nxt;
  always_comb begin
    up_nxt = up_r | ref_tick;
    dn_nxt = dn_r | fb_tick;
    if (up_nxt && dn_nxt) begin
      up_nxt = 1'b0;
      dn_nxt = 1'b0;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
    end
  end

  // output stage, registered
  logic pump_r;
  logic pump_oe_r;
  logic pup_r;
  logic pdn_r;
  logic lock_r;
  logic mon_r;
  logic fls_oe_r;
  logic pump_nxt;
  logic pump_oe_nxt;
  logic pup_nxt;
  logic pdn_nxt;
  logic lock_nxt;
  logic mon_nxt;
  logic fls_oe_nxt;
  logic up_eff;
  logic dn_eff;
  always_comb begin
    // polarity low swaps the pump sense
    up_eff = pol_s ? up_r : dn_r;
    dn_eff = pol_s ? dn_r : up_r;
    pump_nxt = up_eff;
    pump_oe_nxt = up_eff ^ dn_eff;
    pup_nxt = up_eff;
    pdn_nxt = dn_eff;
    lock_nxt = !(up_r || dn_r);
    mon_nxt = pol_s ? ref_tick : fb_tick;
    fls_oe_nxt = strobe_s & pump_oe_nxt;
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pump_r <= 1'b0;
      pump_oe_r <= 1'b0;
      pup_r <= 1'b0;
      pdn_r <= 1'b0;
      lock_r <= 1'b1;
      mon_r <= 1'b0;
      fls_oe_r <= 1'b0;
    end else begin
      pump_r <= pump_nxt;
      pump_oe_r <= pump_oe_nxt;
      pup_r <= pup_nxt;
      pdn_r <= pdn_nxt;
      lock_r <= lock_nxt;
      mon_r <= mon_nxt;
      fls_oe_r <= fls_oe_nxt;
    end
  end
  assign O_PUMP = pump_r;
  assign O_PUMP_OE = pump_oe_r;
  assign O_PUMP_UP = pup_r;
  assign O_PUMP_DN = 1'b0;
  assign O_PUMP_DN_OE = pdn_r;
  assign O_FAST_LOCK_SWITCH_OUT = pump_r;
  assign O_FAST_LOCK_SWITCH_OUT_OE = fls_oe_r;
  assign O_LOCK_DETECT_OUT = lock_r;
  assign O_MONITOR = mon_r;
  assign O_PRESCALER_MODULUS_BIT = mod_bit;
  assign O_PRESCALER_LOW_RATIO = mod_bit ? psd_pkg::MOD_LOW_32 : psd_pkg::MOD_LOW_64;
  assign O_REF_RATIO_BITS = ref_ratio;
  assign O_SWALLOW_RATIO_BITS = swal_ratio;
  assign O_MAIN_RATIO_BITS = main_ratio;

  // checks
  property p_ref_load;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (strobe_s && word_s[0]) |=> (ref_latch_r == $past(word_s[15:1]));
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("ref latch missed load");
  property p_div_load;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (strobe_s && !word_s[0]) |=> (div_latch_r == $past(word_s[18:1]));
  endproperty
  a_div_load: assert property (p_div_load) else $error("div latch missed load");
  property p_hold;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      !strobe_s |=> ($stable(ref_latch_r) && $stable(div_latch_r));
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without strobe");
  property p_fls;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      !$past(strobe_s) |-> !O_FAST_LOCK_SWITCH_OUT_OE;
  endproperty
  a_fls: assert property (p_fls) else $error("fast lock driven with strobe low");
  property p_lock;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (up_r || dn_r) |=> !O_LOCK_DETECT_OUT;
  endproperty
  a_lock: assert property (p_lock) else $error("lock high during phase error");
  property p_mon;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (pol_s && ref_tick) |=> O_MONITOR;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor missed reference");
  property p_pol;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!pol_s && up_r && !dn_r) |=> O_PUMP_DN_OE && !O_PUMP_UP;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not inverted");
  property p_od;
    @(posedge I_CLK) disable iff (I_SYS_RST) !O_PUMP_DN;
  endproperty
  a_od: assert property (p_od) else $error("pump down drove high");
  property p_mod;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      O_PRESCALER_MODULUS_BIT |-> O_PRESCALER_LOW_RATIO == psd_pkg::MOD_LOW_32;
  endproperty
  a_mod: assert property (p_mod) else $error("wrong prescaler modulus");
endmodule // psd_loader

// [rtl/psd_pkg.sv]
// constants for the serial divider loader
package psd_pkg;
  // word layout
  localparam int REF_SHIFT_W = 16;
  localparam int REF_LATCH_W = 15;
  localparam int REF_RATIO_W = 14;
  localparam int DIV_SHIFT_W = 19;
  localparam int DIV_LATCH_W = 18;
  localparam int SWAL_W = 7;
  localparam int MAIN_W = 11;
  localparam int MOD_BIT_POS = 14;
  localparam int MAIN_LSB_POS = 7;
  // ratio limits
  localparam int REF_MIN = 8;
  localparam int MAIN_MIN = 16;
  localparam int SWAL_MAX = 63;
  // prescaler moduli
  localparam logic [6:0] MOD_LOW_32 = 7'h20;
  localparam logic [6:0] MOD_LOW_64 = 7'h40;
  // reset values of the latches
  localparam logic [14:0] REF_LATCH_RST = 15'h4008;
  localparam logic [17:0] DIV_LATCH_RST = 18'h00800;
endpackage : psd_pkg

// [rtl/psd_sync.sv]
// two-stage level synchroniser
`timescale 1ns/10ps
module psd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // level in and out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end
  assign o_q = s2_r;
endmodule // psd_sync

// [verif/pll_serial_divider_loader_tb_top.sv]
// self-checking bench for the serial divider loader
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module pll_serial_divider_loader_tb_top;
  logic clk, rst, lclk, dat, stb, stb_oe, pol, pol_oe, fb;
  logic pump, pump_oe, up, dn, dn_oe, fl, fl_oe, lock, mon, modb;
  logic [6:0] low, swal;
  logic [13:0] refr;
  logic [10:0] mainr;
  int bad_count, n_tests, cyc, mons;
  logic lk_low;

  psd_host_model u_psd_host_model (.o_link_clk(lclk), .o_data(dat), .o_strobe(stb),
    .o_strobe_oe(stb_oe));
  psd_loader u_psd_loader (.I_CLK(clk), .I_SYS_RST(rst), .I_LINK_CLK(lclk), .I_DATA(dat),
    .I_LATCH_STROBE(stb), .I_LATCH_STROBE_OE(stb_oe), .I_PHASE_POLARITY_SELECT(pol),
    .I_PHASE_POLARITY_SELECT_OE(pol_oe), .I_FEEDBACK_IN(fb), .O_PUMP(pump),
    .O_PUMP_OE(pump_oe), .O_PUMP_UP(up), .O_PUMP_DN(dn), .O_PUMP_DN_OE(dn_oe),
    .O_FAST_LOCK_SWITCH_OUT(fl), .O_FAST_LOCK_SWITCH_OUT_OE(fl_oe),
    .O_LOCK_DETECT_OUT(lock), .O_MONITOR(mon), .O_PRESCALER_MODULUS_BIT(modb),
    .O_PRESCALER_LOW_RATIO(low), .O_REF_RATIO_BITS(refr), .O_SWALLOW_RATIO_BITS(swal),
    .O_MAIN_RATIO_BITS(mainr));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard; a clean run needs about 17000 cycles, mostly the 16383 drain
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // compare every latched field
  task automatic fields(input logic [13:0] r, input logic m, input logic [6:0] s,
    input logic [10:0] n);
    `CHK(refr, r)
    `CHK(modb, m)
    `CHK(low, m ? psd_pkg::MOD_LOW_32 : psd_pkg::MOD_LOW_64)
    `CHK(swal, s)
    `CHK(mainr, n)
  endtask
  // shift a word, then pulse the strobe (driven or via pull-up)
  task automatic load(input logic [18:0] w, input int n, input logic pull);
    u_psd_host_model.send_word(w, n);
    @(posedge clk);
    u_psd_host_model.set_strobe(!pull, !pull);
    repeat (5) @(posedge clk);
    #1 `CHK(fl_oe, 1'b1)
    `CHK(fl, 1'b1)
    `CHK(dn, 1'b0)
    @(posedge clk);
    u_psd_host_model.set_strobe(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    #1 `CHK(fl_oe, 1'b0)
  endtask
  // count monitor pulses and flag any lock drop over n cycles
  task automatic watch(input logic p, input logic toggle, input int n);
    mons = 0;
    lk_low = 1'b0;
    @(posedge clk);
    pol <= p;
    pol_oe <= p ? 1'b0 : 1'b1; // high level left to the pull-up
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (toggle && i % 2 == 0) fb <= ~fb;
      #1;
      mons += int'(mon === 1'b1);
      lk_low |= (lock === 1'b0);
    end
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    pol = 1'b1;
    pol_oe = 1'b0;
    fb = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 fields(14'h0008, 1'b1, 7'h00, 11'h010);
    `CHK(lock, 1'b1)
    repeat (4) @(posedge clk);
    load({3'h0, 1'b0, 14'h3FFF, 1'b1}, 16, 1'b0);
    fields(14'h3FFF, 1'b0, 7'h00, 11'h010);
    load({11'h7FF, 7'h3F, 1'b0}, 19, 1'b0);
    fields(14'h3FFF, 1'b0, 7'h3F, 11'h7FF);
    // a word shifted with strobe low moves nothing
    u_psd_host_model.send_word({11'h010, 7'h00, 1'b0}, 19);
    repeat (8) @(posedge clk);
    #1 fields(14'h3FFF, 1'b0, 7'h3F, 11'h7FF);
    load({11'h010, 7'h00, 1'b0}, 19, 1'b0);
    load({3'h0, 1'b1, 14'h0008, 1'b1}, 16, 1'b1);
    fields(14'h0008, 1'b1, 7'h00, 11'h010);
    // the 16383 count taken earlier must run out before ratio 8 reloads
    repeat (16400) @(posedge clk);
    // ratio 8 reference shows about ten ticks in 80 cycles
    watch(1'b1, 1'b0, 80);
    `CHK(mons >= 9 && mons <= 11, 1'b1)
    `CHK(lk_low, 1'b1)
    // reference leads, no feedback: pump pushes up
    `CHK(pump, 1'b1)
    `CHK(pump_oe, 1'b1)
    `CHK(up, 1'b1)
    `CHK(dn_oe, 1'b0)
    `CHK(fl_oe, 1'b0)
    watch(1'b0, 1'b0, 80);
    `CHK(mons, 0)
    // polarity low swaps the sense of pump, up and down-enable; pump enable holds
    `CHK(pump, 1'b0)
    `CHK(pump_oe, 1'b1)
    `CHK(up, 1'b0)
    `CHK(dn_oe, 1'b1)
    // 32 feedback rises at ratio 16 give about two ticks
    watch(1'b0, 1'b1, 128);
    `CHK(mons >= 1 && mons <= 3, 1'b1)
    print_verdict();
  end
endmodule // pll_serial_divider_loader_tb_top

// [verif/psd_host_model.sv]
// host-side model of the three-wire programming link
`timescale 1ns/10ps
module psd_host_model (
  // serial link pins
  output logic o_link_clk,
  output logic o_data,
  output logic o_strobe,
  output logic o_strobe_oe
);
  // link idle: clock parked low, strobe driven low
  initial begin
    o_link_clk = 1'b0;
    o_data = 1'b0;
    o_strobe = 1'b0;
    o_strobe_oe = 1'b1;
  end
  // shift n bits msb first at a 15 ns link period
  task automatic send_word(input logic [18:0] w, input int n);
    #3.3;
    for (int i = n - 1; i >= 0; i--) begin
      o_data = w[i];
      #7.5 o_link_clk = 1'b1;
      #7.5 o_link_clk = 1'b0;
    end
    // data has no pull: show the inverse, never the stale bit
    #7.5 o_data = ~w[0];
  endtask
  // strobe drive; oe low leaves the pin to its pull-up
  task automatic set_strobe(input logic lvl, input logic oe);
    o_strobe <= lvl;
    o_strobe_oe <= oe;
  endtask
endmodule // psd_host_model
